// ==== rtl/fac_pkg.sv ====
// package: register map, field layout, reset value and ramp timing of the acoustic config block
`default_nettype none
package fac_pkg;
  localparam logic [7:0] FAC_ACOU_CFG_ADDR  = 8'h62;
  localparam logic [7:0] FAC_ACOU_CFG_RESET = 8'h00;
  localparam int         FAC_RATE_LSB       = 0;
  localparam int         FAC_SMOOTH_EN_BIT  = 3;
  localparam int         FAC_SYNC_BIT       = 4;
  localparam int         FAC_FLOOR1_BIT     = 5;
  localparam int         FAC_FLOOR2_BIT     = 6;
  localparam int         FAC_FLOOR3_BIT     = 7;
  localparam int         FAC_CHANNELS       = 3;
  localparam int         FAC_DUTY_W         = 8;
  localparam int         FAC_SLOW_FACTOR    = 4;
  localparam int         FAC_SYS_CLK_HZ     = 20_000_000;
  // full 0% to 100% sweep at one step per slot, in milliseconds
  localparam longint     FAC_SWEEP_FAST_MS  = 37500;
  localparam longint     FAC_SWEEP_SLOW_MS  = 52200;
  localparam longint     FAC_SWEEP_STEPS    = 255;
  localparam longint     FAC_SLOT_FAST_CYC  =
    (FAC_SWEEP_FAST_MS * FAC_SYS_CLK_HZ) / (1000 * FAC_SWEEP_STEPS);
  localparam longint     FAC_SLOT_SLOW_CYC  =
    (FAC_SWEEP_SLOW_MS * FAC_SYS_CLK_HZ) / (1000 * FAC_SWEEP_STEPS);

  // register image, msb first
  typedef struct packed {
    logic       floor_sel_3;
    logic       floor_sel_2;
    logic       floor_sel_1;
    logic       tach_group_select;
    logic       remote1_smooth_enable;
    logic [2:0] rate_code;
  } fac_cfg_s;

  typedef logic [FAC_DUTY_W-1:0] fac_duty_t;

  // per drive channel control inputs from the fan control loop
  typedef struct packed {
    fac_duty_t  target_duty;
    fac_duty_t  min_duty;
    logic       below_start;
    logic       from_remote1;
  } fac_chan_s;

  function automatic fac_duty_t fac_step_size(input logic [2:0] code);
    fac_duty_t s;
    s = 8'h01;
    case (code)
      3'h0: s = 8'h01;
      3'h1: s = 8'h02;
      3'h2: s = 8'h03;
      3'h3: s = 8'h04;
      3'h4: s = 8'h08;
      3'h5: s = 8'h0C;
      3'h6: s = 8'h18;
      default: s = 8'h30;
    endcase
    return s;
  endfunction : fac_step_size
endpackage : fac_pkg
`default_nettype wire

// ==== rtl/fac_duty_ramp.sv ====
// one drive channel: rate-limited walk of the applied duty toward its target
`default_nettype none
module fac_duty_ramp
  import fac_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      sys_rst,
  input  wire logic      smooth_on,
  input  wire logic      slot_tick,
  input  wire fac_duty_t step,
  input  wire fac_duty_t target,
  output fac_duty_t      duty
);
  fac_duty_t   duty_r;
  fac_duty_t   duty_nxt;
  logic [8:0]  up_sum;
  logic [8:0]  down_dif;

  always_comb begin
    up_sum   = {1'b0, duty_r} + {1'b0, step};
    down_dif = {1'b0, duty_r} - {1'b0, step};
    duty_nxt = duty_r;
    if (!smooth_on) begin
      duty_nxt = target;
    end else if (slot_tick) begin
      if (target > duty_r) begin
        duty_nxt = (up_sum[8] || up_sum[7:0] > target) ? target : up_sum[7:0];
      end else if (target < duty_r) begin
        duty_nxt = (down_dif[8] || down_dif[7:0] < target) ? target : down_dif[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      duty_r <= '0;
    end else begin
      duty_r <= duty_nxt;
    end
  end

  assign duty = duty_r;
endmodule : fac_duty_ramp
`default_nettype wire

// ==== rtl/fac_acoustic_cfg.sv ====
// acoustic enhancement config register with floor select, tach sync and remote1 smoothing
`default_nettype none
module fac_acoustic_cfg
  import fac_pkg::*;
#(
  parameter int unsigned SLOT_FAST_CYC = 32'(FAC_SLOT_FAST_CYC),
  parameter int unsigned SLOT_SLOW_CYC = 32'(FAC_SLOT_SLOW_CYC)
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // register access
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // state held elsewhere in the register map
  input  wire logic       cfg_lock,
  input  wire logic       slow_time_base,
  input  wire logic       remote1_slow_ramp,
  input  wire logic       auto_mode,
  // fan control loop, one entry per drive output
  input  wire fac_chan_s  chan_1,
  input  wire fac_chan_s  chan_2,
  input  wire fac_chan_s  chan_3,
  output fac_duty_t       fan_drive_out_1,
  output fac_duty_t       fan_drive_out_2,
  output fac_duty_t       fan_drive_out_3,
  // speed sense pins and their assignment to drive output 3
  input  wire logic       fan_speed_in_2,
  input  wire logic       fan_speed_in_3,
  input  wire logic       fan_speed_in_4,
  output logic [2:0]      fan_speed_sync,
  output logic [2:0]      sync_to_drive3
);
  fac_cfg_s    cfg_r;
  fac_cfg_s    cfg_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic [31:0] slot_cnt_r;
  logic [31:0] slot_cnt_nxt;
  logic [31:0] slot_len;
  logic        slot_tick;
  logic [2:0]  speed_meta_r;
  logic [2:0]  speed_sync_r;
  logic [2:0]  sync_mask_r;
  logic [2:0]  sync_mask_nxt;
  fac_duty_t   step;
  fac_chan_s   chan       [FAC_CHANNELS];
  fac_duty_t   duty_out   [FAC_CHANNELS];
  logic [FAC_CHANNELS-1:0] floor_sel;

  // register write and read
  always_comb begin
    cfg_nxt   = cfg_r;
    rdata_nxt = rdata_r;
    if (reg_wr && reg_addr == FAC_ACOU_CFG_ADDR) begin
      if (!cfg_lock) begin
        cfg_nxt = fac_cfg_s'(reg_wdata);
      end
    end
    if (reg_rd) begin
      if (reg_addr == FAC_ACOU_CFG_ADDR) begin
        rdata_nxt = 8'(cfg_r);
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_r   <= fac_cfg_s'(FAC_ACOU_CFG_RESET);
      rdata_r <= 8'h00;
    end else begin
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // smoothing time slot
  always_comb begin
    slot_len = slow_time_base ? SLOT_SLOW_CYC : SLOT_FAST_CYC;
    if (remote1_slow_ramp) begin
      slot_len = 32'(slot_len * FAC_SLOW_FACTOR);
    end
    slot_tick    = (slot_cnt_r >= slot_len - 32'h1);
    slot_cnt_nxt = slot_tick ? 32'h0 : slot_cnt_r + 32'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      slot_cnt_r <= 32'h0;
    end else begin
      slot_cnt_r <= slot_cnt_nxt;
    end
  end

  assign step = fac_step_size(cfg_r.rate_code);

  // speed pins pass two flops, then the group assignment to drive 3
  always_comb begin
    sync_mask_nxt = {2'b11, cfg_r.tach_group_select};
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      speed_meta_r <= 3'h0;
      speed_sync_r <= 3'h0;
      sync_mask_r  <= 3'h0;
    end else begin
      speed_meta_r <= {fan_speed_in_4, fan_speed_in_3, fan_speed_in_2};
      speed_sync_r <= speed_meta_r;
      sync_mask_r  <= sync_mask_nxt;
    end
  end

  assign fan_speed_sync = speed_sync_r;
  assign sync_to_drive3 = sync_mask_r;

  // per drive channel: floor choice below start, then smoothing
  assign chan[0]   = chan_1;
  assign chan[1]   = chan_2;
  assign chan[2]   = chan_3;
  assign floor_sel = {cfg_r.floor_sel_3, cfg_r.floor_sel_2, cfg_r.floor_sel_1};

  generate
    for (genvar i = 0; i < FAC_CHANNELS; i++) begin : g_chan
      fac_duty_t target;
      logic      smooth_on;

      always_comb begin
        target = chan[i].target_duty;
        if (auto_mode && chan[i].below_start) begin
          target = floor_sel[i] ? chan[i].min_duty : '0;
        end
        smooth_on = cfg_r.remote1_smooth_enable && chan[i].from_remote1;
      end

      fac_duty_ramp u_ramp (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .smooth_on (smooth_on),
        .slot_tick (slot_tick),
        .step      (step),
        .target    (target),
        .duty      (duty_out[i])
      );
    end
  endgenerate

  assign fan_drive_out_1 = duty_out[0];
  assign fan_drive_out_2 = duty_out[1];
  assign fan_drive_out_3 = duty_out[2];
endmodule : fac_acoustic_cfg
`default_nettype wire

// ==== tb/fac_acoustic_cfg_asserts.sv ====
// checker: port relations of the acoustic config block
`default_nettype none
module fac_acoustic_cfg_asserts
  import fac_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       cfg_lock,
  input wire logic       auto_mode,
  input wire fac_chan_s  chan_1,
  input wire fac_chan_s  chan_2,
  input wire fac_duty_t  fan_drive_out_1,
  input wire fac_duty_t  fan_drive_out_2,
  input wire logic       fan_speed_in_2,
  input wire logic       fan_speed_in_3,
  input wire logic       fan_speed_in_4,
  input wire logic [2:0] fan_speed_sync,
  input wire logic [2:0] sync_to_drive3
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence locked2;
    cfg_lock ##1 cfg_lock;
  endsequence
  a_sync_fixed: assert property (!$past(sys_rst) |-> sync_to_drive3[2:1] == 2'b11)
    else $error("speed inputs 3 and 4 not tied to drive 3");
  a_lock_hold: assert property (locked2 |=> $stable(sync_to_drive3))
    else $error("locked register changed");
  a_group_follow: assert property (reg_rd && reg_addr == FAC_ACOU_CFG_ADDR |=>
    sync_to_drive3[0] == reg_rdata[FAC_SYNC_BIT]) else $error("group select not applied");
  a_direct_duty: assert property (!chan_1.from_remote1 && !auto_mode |=>
    fan_drive_out_1 == $past(chan_1.target_duty)) else $error("duty not applied at once");
  a_floor_out: assert property (auto_mode && chan_2.below_start && !chan_2.from_remote1 |=>
    fan_drive_out_2 == 8'h00 || fan_drive_out_2 == $past(chan_2.min_duty))
    else $error("drive 2 below start not off or minimum");
  a_speed_sync: assert property (1 |-> ##2 fan_speed_sync ==
    $past({fan_speed_in_4, fan_speed_in_3, fan_speed_in_2}, 2)) else $error("speed sync");
  a_rd_unmapped: assert property (reg_rd && reg_addr != FAC_ACOU_CFG_ADDR |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
endmodule : fac_acoustic_cfg_asserts
`default_nettype wire

// ==== tb/fac_fan_model.sv ====
// fan model: tach output whose rate follows the applied duty
`default_nettype none
module fac_fan_model
  import fac_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire fac_duty_t duty,
  output logic           tach
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] acc_r = 12'h000;
  always @(posedge sys_clk) acc_r <= acc_r + 12'(duty);
  assign tach = acc_r[11];
endmodule : fac_fan_model
`default_nettype wire

// ==== tb/tb_fan_acoustic_config_bits.sv ====
// testbench: register, floor, tach grouping and smoothing of the acoustic config block
`default_nettype none
module tb_fan_acoustic_config_bits
  import fac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, sys_rst = 1, wr = 0, rd = 0, lock = 0, slow = 0, auto = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  fac_chan_s  ch [3] = '{default: '0};
  fac_duty_t  o1, o2, o3;
  wire logic [2:0] t;
  logic [2:0] sync_o, grp;
  int mismatches = 0, n_tests = 0, cyc = 0;
  fac_acoustic_cfg #(.SLOT_FAST_CYC(4), .SLOT_SLOW_CYC(6)) i_dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd),
    .reg_rdata(rdata), .cfg_lock(lock), .slow_time_base(1'b0), .remote1_slow_ramp(slow),
    .auto_mode(auto), .chan_1(ch[0]), .chan_2(ch[1]), .chan_3(ch[2]),
    .fan_drive_out_1(o1), .fan_drive_out_2(o2), .fan_drive_out_3(o3),
    .fan_speed_in_2(t[0]), .fan_speed_in_3(t[1]), .fan_speed_in_4(t[2]),
    .fan_speed_sync(sync_o), .sync_to_drive3(grp));
  fac_fan_model i_fan2 (.sys_clk(sys_clk), .duty(o3), .tach(t[0]));
  fac_fan_model i_fan3 (.sys_clk(sys_clk), .duty(o2), .tach(t[1]));
  fac_fan_model i_fan4 (.sys_clk(sys_clk), .duty(o1), .tach(t[2]));
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      mismatches++;
    end
  endtask : chk
  task automatic le(input logic [7:0] g, input logic [7:0] lim);
    n_tests++;
    if ((^g === 1'bx) || (g > lim)) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, lim);
      mismatches++;
    end
  endtask : le
  task automatic cyc_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc_n
  task automatic wreg(input logic [7:0] d);
    @(negedge sys_clk);
    {addr, wd, wr} = {FAC_ACOU_CFG_ADDR, d, 1'b1};
    @(negedge sys_clk);
    wr = 0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    {addr, rd} = {a, 1'b1};
    @(negedge sys_clk);
    rd = 0;
    chk(rdata, e);
  endtask : rreg
  task automatic t_lock();
    rreg(FAC_ACOU_CFG_ADDR, 8'h00);
    rreg(8'h10, 8'h00);
    lock = 1;
    wreg(8'hFF);
    rreg(FAC_ACOU_CFG_ADDR, 8'h00);
    lock = 0;
    wreg(8'hE0);
    rreg(FAC_ACOU_CFG_ADDR, 8'hE0);
  endtask : t_lock
  task automatic t_floor();
    auto = 1;
    foreach (ch[i]) ch[i] = '{8'h70, 8'h33, 1'b1, 1'b0};
    cyc_n(2);
    chk(o1, 8'h33);
    chk(o2, 8'h33);
    chk(o3, 8'h33);
    wreg(8'h00);
    cyc_n(2);
    chk(o1 | o2 | o3, 8'h00);
    auto = 0;
    cyc_n(2);
    chk(o3, 8'h70);
  endtask : t_floor
  task automatic t_group();
    wreg(8'h10);
    cyc_n(2);
    chk(8'(grp), 8'h07);
    wreg(8'h00);
    cyc_n(2);
    chk(8'(grp), 8'h06);
  endtask : t_group
  task automatic t_smooth(input logic s, input int n, input logic [7:0] lim);
    ch[0] = '{8'h00, 8'h00, 1'b0, 1'b0};
    slow = s;
    wreg(8'h0B);
    cyc_n(2);
    ch[0] = '{8'h10, 8'h00, 1'b0, 1'b1};
    cyc_n(1);
    le(o1, 8'h04);
    cyc_n(n);
    le(o1, lim);
    cyc_n(80);
    chk(o1, 8'h10);
  endtask : t_smooth
  task automatic print_verdict();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    cyc_n(2);
    sys_rst = 0;
    t_lock();
    t_floor();
    t_group();
    t_smooth(1'b0, 6, 8'h08);
    t_smooth(1'b1, 20, 8'h08);
    print_verdict();
  end
endmodule : tb_fan_acoustic_config_bits
bind fac_acoustic_cfg fac_acoustic_cfg_asserts u_chk (.*);
`default_nettype wire
